// file: src/dbg_port_pkg.sv
// Constants shared by the debug register access port and its word store.
// Assumes one clock for the bus and the store; no software-side registers.
package dbg_port_pkg;

  // ----------------------------------------
  // Bus widths, store depth and counter width
  // ----------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned WADDR_W = 15;
  localparam int unsigned INDEX_W = 4;
  localparam int unsigned DEPTH   = 16;
  localparam int unsigned CNT_W   = 8;

  // ----------------------------------------
  // Word map
  // ----------------------------------------
  localparam logic [INDEX_W-1:0] STATUS_INDEX   = 4'h0;
  localparam logic [INDEX_W-1:0] EXT_ONLY_FIRST = 4'h8;
  localparam int unsigned        STATUS_PAD_W   = DATA_W - 2 * CNT_W;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 8'h00;

endpackage

// file: src/dbg_word_store.sv
// Word store behind the debug port: one write port, one combinational read.
// Assumes writes come from the port logic on the same clock.
`timescale 1ns/100ps

module dbg_word_store (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // Write side
  input  wire logic                                wr_en,
  input  wire logic [dbg_port_pkg::INDEX_W-1:0]    wr_index,
  input  wire logic [dbg_port_pkg::DATA_W-1:0]     wr_data,
  // Read side
  input  wire logic [dbg_port_pkg::INDEX_W-1:0]    rd_index,
  output logic      [dbg_port_pkg::DATA_W-1:0]     rd_data
);

  typedef struct packed {
    logic [dbg_port_pkg::DEPTH-1:0][dbg_port_pkg::DATA_W-1:0] mem;
  } store_state_t;

  store_state_t state_q;
  store_state_t state_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.mem[wr_index] = wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.mem[rd_index];

endmodule

// file: src/debug_apb_slave_port.sv
// Debug register access port: a bus slave in front of the debug word store.
// Assumes the bus master runs on mclk and keeps the usual setup/access order.
`timescale 1ns/100ps

// Functional notes
// - The port is held in reset while its own reset input is low and runs when it is high and sys_rst is low.
// - The external_debugger_flag input marks a debugger access, and the port treats the two origins apart.
// - The port may hold ready low to add wait states; a transfer ends only with ready high.
// - The error output is high in the completing cycle of a failed access, low otherwise.
module debug_apb_slave_port (
  // Clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  dbg_port_reset_n,
  // Bus request
  input  wire logic                                  dbg_port_clock_en,
  input  wire logic                                  dbg_regs_select,
  input  wire logic                                  dbg_port_access_phase,
  input  wire logic                                  dbg_port_write_dir,
  input  wire logic [dbg_port_pkg::WADDR_W-1:0]      dbg_port_word_addr,
  input  wire logic                                  external_debugger_flag,
  input  wire logic [dbg_port_pkg::DATA_W-1:0]       dbg_port_write_bus,
  // Bus answer
  output logic      [dbg_port_pkg::DATA_W-1:0]       dbg_port_read_bus,
  output logic                                       dbg_port_ready_out,
  output logic                                       dbg_port_error_out
);

  typedef struct packed {
    logic                                ready;
    logic                                err;
    logic [dbg_port_pkg::DATA_W-1:0]     rdata;
    logic [dbg_port_pkg::CNT_W-1:0]      ext_cnt;
    logic [dbg_port_pkg::CNT_W-1:0]      int_cnt;
  } port_state_t;

  port_state_t                         state_q;
  port_state_t                         state_d;
  logic                                port_rst;
  logic                                access_req;
  logic                                bad_addr;
  logic                                bad_origin;
  logic                                bad_status_wr;
  logic                                wr_en;
  logic [dbg_port_pkg::INDEX_W-1:0]    index;
  logic [dbg_port_pkg::DATA_W-1:0]     store_rd;
  logic [dbg_port_pkg::DATA_W-1:0]     status_word;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Either reset source clears the port; the bus reset alone is enough
  assign port_rst = sys_rst | ~dbg_port_reset_n;

  // Ready is registered, so every access costs one wait state; that keeps
  // the answer straight off a flip-flop at the cost of bus throughput
  assign access_req = dbg_port_clock_en & dbg_regs_select & dbg_port_access_phase
                      & ~state_q.ready;

  assign index         = dbg_port_word_addr[dbg_port_pkg::INDEX_W-1:0];
  assign bad_addr      = |dbg_port_word_addr[dbg_port_pkg::WADDR_W-1:dbg_port_pkg::INDEX_W];
  assign bad_origin    = ~external_debugger_flag
                         & (index >= dbg_port_pkg::EXT_ONLY_FIRST);
  assign bad_status_wr = dbg_port_write_dir & (index == dbg_port_pkg::STATUS_INDEX);
  assign status_word   = {{dbg_port_pkg::STATUS_PAD_W{1'b0}}, state_q.ext_cnt, state_q.int_cnt};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    wr_en   = 1'b0;
    if (access_req) begin
      state_d.ready = 1'b1;
      state_d.err   = bad_addr | bad_origin | bad_status_wr;
      if (!(bad_addr | bad_origin | bad_status_wr)) begin
        if (dbg_port_write_dir) begin
          wr_en = 1'b1;
        end else if (index == dbg_port_pkg::STATUS_INDEX) begin
          state_d.rdata = status_word;
        end else begin
          state_d.rdata = store_rd;
        end
      end
      // Counters wrap; they only show which origin has been active
      if (external_debugger_flag) begin
        state_d.ext_cnt = state_q.ext_cnt + 8'h01;
      end else begin
        state_d.int_cnt = state_q.int_cnt + 8'h01;
      end
    end else if (dbg_port_clock_en && state_q.ready) begin
      // Completion is seen by the master on this enabled edge
      state_d.ready = 1'b0;
      state_d.err   = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (port_rst) begin
      state_q.ready   <= 1'b0;
      state_q.err     <= 1'b0;
      state_q.rdata   <= dbg_port_pkg::WORD_RESET;
      state_q.ext_cnt <= dbg_port_pkg::CNT_RESET;
      state_q.int_cnt <= dbg_port_pkg::CNT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Word store
  // ----------------------------------------
  dbg_word_store u_store (
    .mclk     (mclk),
    .rst      (port_rst),
    .wr_en    (wr_en),
    .wr_index (index),
    .wr_data  (dbg_port_write_bus),
    .rd_index (index),
    .rd_data  (store_rd)
  );

  assign dbg_port_read_bus  = state_q.rdata;
  assign dbg_port_ready_out = state_q.ready;
  assign dbg_port_error_out = state_q.err;

endmodule

// file: tb/debug_apb_slave_port_monitor.sv
// Checker for the debug port bus timing and error flag.
// Assumes it is bound to the port's top module; one clock.
`timescale 1ns/100ps
module debug_apb_slave_port_monitor (
  input wire logic                               mclk,
  input wire logic                               sys_rst,
  input wire logic                               dbg_port_reset_n,
  input wire logic                               dbg_port_clock_en,
  input wire logic                               dbg_regs_select,
  input wire logic                               dbg_port_access_phase,
  input wire logic [dbg_port_pkg::WADDR_W-1:0]   dbg_port_word_addr,
  input wire logic                               external_debugger_flag,
  input wire logic                               dbg_port_ready_out,
  input wire logic                               dbg_port_error_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || !dbg_port_reset_n);
  sequence s_take;
    dbg_port_clock_en && dbg_regs_select && dbg_port_access_phase && !dbg_port_ready_out;
  endsequence
  property p_rst; disable iff (1'b0) sys_rst || !dbg_port_reset_n |=> !dbg_port_ready_out; endproperty
  a_rst: assert property (p_rst) else $error("ready in reset");
  property p_ext;
    s_take ##0 (!external_debugger_flag && dbg_port_word_addr[3]) |=> dbg_port_error_out;
  endproperty
  a_ext: assert property (p_ext) else $error("origin not refused");
  property p_wait; s_take |=> dbg_port_ready_out; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_drop; dbg_port_ready_out && dbg_port_clock_en |=> !dbg_port_ready_out; endproperty
  a_drop: assert property (p_drop) else $error("ready stuck");
  property p_err; dbg_port_error_out |-> dbg_port_ready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hold; dbg_port_ready_out && !dbg_port_clock_en |=> $stable(dbg_port_ready_out); endproperty
  a_hold: assert property (p_hold) else $error("moved while disabled");
  property p_ignore; !dbg_regs_select && !dbg_port_ready_out |=> !dbg_port_ready_out; endproperty
  a_ignore: assert property (p_ignore) else $error("answered without select");
endmodule
bind debug_apb_slave_port debug_apb_slave_port_monitor mon_inst (.*);

// file: tb/dbg_master_model.sv
// Bus master model that drives the debug port.
// Assumes the bench drives clock enable and reset itself.
`timescale 1ns/100ps
module dbg_master_model (
  input  wire logic        mclk,
  input  wire logic        dbg_port_clock_en,
  input  wire logic        dbg_port_ready_out,
  input  wire logic        dbg_port_error_out,
  input  wire logic [31:0] dbg_port_read_bus,
  output logic             dbg_regs_select,
  output logic             dbg_port_access_phase,
  output logic             dbg_port_write_dir,
  output logic             external_debugger_flag,
  output logic [14:0]      dbg_port_word_addr,
  output logic [31:0]      dbg_port_write_bus
);
  initial begin
    {dbg_regs_select, dbg_port_access_phase, dbg_port_write_dir, external_debugger_flag} = 4'h0;
    dbg_port_word_addr = 15'h0000;
    dbg_port_write_bus = 32'h0000_0000;
  end
  task automatic xfer(input logic w, x, input logic [14:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk) #1 dbg_regs_select = 1;
    {dbg_port_write_dir, external_debugger_flag, dbg_port_word_addr} = {w, x, a};
    dbg_port_write_bus = d;
    // The bus only moves on enabled edges, so setup and completion wait for one
    do @(posedge mclk); while (dbg_port_clock_en !== 1'b1);
    #1 dbg_port_access_phase = 1;
    do @(posedge mclk); while (dbg_port_ready_out !== 1'b1 || dbg_port_clock_en !== 1'b1);
    q = dbg_port_read_bus;
    e = dbg_port_error_out;
    // Released lines show the inverse so stale values cannot pass
    #1 {dbg_regs_select, dbg_port_access_phase} = 2'h0;
    {dbg_port_write_dir, external_debugger_flag, dbg_port_word_addr} = ~{w, x, a};
    dbg_port_write_bus = ~d;
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the debug register access port.
// Assumes the master model file and the bound checker compile first.
`timescale 1ns/100ps
module tb;
  logic mclk = 0, sys_rst = 1, dbg_port_reset_n = 1, dbg_port_clock_en = 1;
  logic dbg_regs_select, dbg_port_access_phase, dbg_port_write_dir, external_debugger_flag;
  logic dbg_port_ready_out, dbg_port_error_out, e;
  logic [14:0] dbg_port_word_addr;
  logic [31:0] dbg_port_write_bus, dbg_port_read_bus, q;
  int failures = 0, samples_checked = 0;
  typedef struct {logic w, x; logic [14:0] a; logic [31:0] d, q; logic e;} row_t;
  row_t rows[10] = '{'{1, 0, 15'h1, 32'hA5A5_0001, 0, 0}, '{0, 0, 15'h1, 0, 32'hA5A5_0001, 0},
    '{1, 1, 15'h0, 32'h1234, 0, 1}, '{1, 0, 15'h9, 32'hDEAD_BEEF, 0, 1},
    '{1, 1, 15'h9, 32'hC0DE_0009, 0, 0}, '{0, 1, 15'h9, 0, 32'hC0DE_0009, 0},
    '{0, 0, 15'h9, 0, 0, 1}, '{1, 1, 15'h10, 32'h1, 0, 1}, '{0, 1, 15'h1, 0, 32'hA5A5_0001, 0},
    '{0, 1, 15'h0, 0, 32'h0000_0504, 0}};
  debug_apb_slave_port debug_apb_slave_port_inst (.*);
  dbg_master_model dbg_master_model_inst (.*);
  initial forever #20 mclk = ~mclk;
  task chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task chk_err(input logic g, x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task wrap_up;
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000 failures++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 sys_rst = 0;
    foreach (rows[i]) begin
      dbg_master_model_inst.xfer(rows[i].w, rows[i].x, rows[i].a, rows[i].d, q, e);
      chk_err(e, rows[i].e);
      if (!rows[i].w && !rows[i].e) chk(q, rows[i].q);
    end
    // Clock enable drops in mid-transfer; the access must simply wait
    fork
      dbg_master_model_inst.xfer(1, 0, 15'h2, 32'h5A5A_0002, q, e);
      begin
        repeat (2) @(posedge mclk);
        #1 dbg_port_clock_en = 0;
        repeat (3) @(posedge mclk);
        #1 dbg_port_clock_en = 1;
      end
    join
    dbg_master_model_inst.xfer(0, 0, 15'h2, 0, q, e);
    chk(q, 32'h5A5A_0002);
    // Ready must stand through edges with the enable low
    fork
      dbg_master_model_inst.xfer(1, 0, 15'h3, 32'h5A5A_0003, q, e);
      begin
        @(posedge dbg_port_ready_out) #1 dbg_port_clock_en = 0;
        repeat (3) @(posedge mclk);
        #1 chk_err(dbg_port_ready_out, 1'b1);
        dbg_port_clock_en = 1;
      end
    join
    chk_err(e, 1'b0);
    dbg_master_model_inst.xfer(0, 0, 15'h3, 0, q, e);
    chk(q, 32'h5A5A_0003);
    @(posedge mclk) #1 dbg_port_reset_n = 0;
    repeat (2) @(posedge mclk);
    #1 dbg_port_reset_n = 1;
    dbg_master_model_inst.xfer(0, 0, 15'h2, 0, q, e);
    chk(q, 32'h0000_0000);
    wrap_up;
  end
endmodule
